/* File: pkg/eth_stats_pkg.sv */
// shared constants for the ethernet mac statistics counter block
`default_nettype none
package eth_stats_pkg;

	// ------------------------------------------------------------
	// bus and field widths
	// ------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int NUM_CNT = 9;
	localparam int LEN_W   = 11;
	localparam int COLL_W  = 5;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_USER_IO     = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PAUSE_RX_OK = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_TX_OK       = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SINGLE_COLL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_MULTI_COLL  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RX_OK       = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CRC_ERR     = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_ALIGN_ERR   = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_DEFER_TX    = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_LATE_COLL   = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_NET_CONTROL = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_NET_CONFIG  = 8'h2C;

	// ------------------------------------------------------------
	// counter bank: index, width and offset of each counter
	// ------------------------------------------------------------
	localparam int IDX_PAUSE  = 0;
	localparam int IDX_TX_OK  = 1;
	localparam int IDX_SINGLE = 2;
	localparam int IDX_MULTI  = 3;
	localparam int IDX_RX_OK  = 4;
	localparam int IDX_CRC    = 5;
	localparam int IDX_ALIGN  = 6;
	localparam int IDX_DEFER  = 7;
	localparam int IDX_LATE   = 8;
	localparam int CNT_W [NUM_CNT] = '{16, 24, 16, 16, 24, 8, 8, 16, 8};
	localparam logic [ADDR_W-1:0] CNT_OFF [NUM_CNT] = '{OFF_PAUSE_RX_OK, OFF_TX_OK, OFF_SINGLE_COLL,
		OFF_MULTI_COLL, OFF_RX_OK, OFF_CRC_ERR, OFF_ALIGN_ERR, OFF_DEFER_TX, OFF_LATE_COLL};

	// ------------------------------------------------------------
	// control field positions and reset values
	// ------------------------------------------------------------
	localparam int UIO_RMII_BIT      = 0;
	localparam int UIO_XCVR_CLOCK_GATE_BIT     = 1;
	localparam int NCTL_RX_EN_BIT    = 2;
	localparam int NCTL_STATS_WE_BIT = 7;
	localparam int NCFG_BIG_BIT      = 8;
	localparam logic RMII_RST     = 1'b0;
	localparam logic XCVR_CLOCK_GATE_RST    = 1'b0;
	localparam logic RX_EN_RST    = 1'b0;
	localparam logic STATS_WE_RST = 1'b0;
	localparam logic BIG_RST      = 1'b0;

	// ------------------------------------------------------------
	// frame length and collision limits
	// ------------------------------------------------------------
	localparam logic [LEN_W-1:0]  MIN_LEN        = 11'd64;
	localparam logic [LEN_W-1:0]  MAX_LEN        = 11'd1518;
	localparam logic [LEN_W-1:0]  MAX_LEN_BIG    = 11'd1536;
	localparam logic [COLL_W-1:0] COLL_ONE       = 5'd1;
	localparam logic [COLL_W-1:0] COLL_MULTI_MIN = 5'd2;
	localparam logic [COLL_W-1:0] COLL_MULTI_MAX = 5'd15;

endpackage
`default_nettype wire

/* File: hw/stat_sat_counter.sv */
// one clear-on-read saturating statistics counter, zero extended to a bus word
`timescale 1ns/1ps
`default_nettype none
module stat_sat_counter #(
	parameter int W = 8
) (
	input  wire logic                              clk_sys,
	input  wire logic                              srst,
	input  wire logic                              inc,
	input  wire logic                              rd_clr,
	input  wire logic                              wr_en,
	input  wire logic [W-1:0]                      wr_data,
	output logic      [eth_stats_pkg::DATA_W-1:0]  count
);
	import eth_stats_pkg::*;

	logic [W-1:0] count_q;

	// write wins, then read-clear; an event in the clearing cycle leaves one
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			count_q <= '0;
		end else if (wr_en) begin
			count_q <= wr_data;
		end else if (rd_clr) begin
			count_q <= inc ? W'(1) : '0;
		end else if (inc && (count_q != {W{1'b1}})) begin
			count_q <= count_q + W'(1);
		end
	end

	// bits above the counter width read as zero
	assign count = {{(DATA_W-W){1'b0}}, count_q};
endmodule
`default_nettype wire

/* File: hw/rx_frame_classify.sv */
// sorts one received frame report into good, crc fault and alignment fault
`timescale 1ns/1ps
`default_nettype none
module rx_frame_classify (
	input  wire logic [eth_stats_pkg::LEN_W-1:0] rx_len,
	input  wire logic                            rx_dribble,
	input  wire logic                            rx_crc_bad,
	input  wire logic                            rx_symbol_err,
	input  wire logic                            big_frames,
	output logic                                 len_valid,
	output logic                                 frame_good,
	output logic                                 crc_fault,
	output logic                                 align_fault
);
	import eth_stats_pkg::*;

	logic [LEN_W-1:0] max_len;
	logic             bad_frame;

	// the upper length limit moves when big frames are allowed
	assign max_len   = big_frames ? MAX_LEN_BIG : MAX_LEN;
	assign len_valid = (rx_len >= MIN_LEN) && (rx_len <= max_len);
	// a symbol error is filed with crc faults when the length is valid and there is no dribble, with alignment faults when valid with dribble
	assign bad_frame   = rx_crc_bad || rx_symbol_err;
	assign frame_good  = len_valid && !bad_frame;
	assign crc_fault   = len_valid && !rx_dribble && bad_frame;
	assign align_fault = len_valid && rx_dribble && bad_frame;
endmodule
`default_nettype wire

/* File: hw/eth_mac_stats_counters.sv */
// ethernet mac user i/o control and first bank of frame statistics counters
`timescale 1ns/1ps
`default_nettype none

module eth_mac_stats_counters (
	input  wire logic                                 clk_sys,
	input  wire logic                                 srst,
	input  wire logic [eth_stats_pkg::ADDR_W-1:0]     reg_addr,
	input  wire logic [eth_stats_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                                 reg_wr,
	input  wire logic                                 reg_rd,
	output logic      [eth_stats_pkg::DATA_W-1:0]     reg_rdata,
	output logic                                      rmii_select,
	output logic                                      xcvr_clock_gate,
	output logic                                      rx_enable,
	output logic                                      big_frames,
	input  wire logic                                 rx_frame_done,
	input  wire logic [eth_stats_pkg::LEN_W-1:0]      rx_len,
	input  wire logic                                 rx_dribble,
	input  wire logic                                 rx_crc_bad,
	input  wire logic                                 rx_symbol_err,
	input  wire logic                                 rx_pause,
	input  wire logic                                 rx_addr_match,
	input  wire logic                                 rx_stored,
	input  wire logic                                 tx_frame_done,
	input  wire logic                                 tx_underrun,
	input  wire logic                                 tx_retry_limit,
	input  wire logic [eth_stats_pkg::COLL_W-1:0]     tx_collisions,
	input  wire logic                                 tx_deferred,
	input  wire logic                                 tx_late_collision
);
	import eth_stats_pkg::*;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic rmii_q;
	logic xcvr_clock_gate_q;
	logic rx_en_q;
	logic stats_we_q;
	logic big_q;

	// user i/o control: interface select and transceiver clock enable
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rmii_q  <= RMII_RST;
			xcvr_clock_gate_q <= XCVR_CLOCK_GATE_RST;
		end else if (reg_wr && (reg_addr == OFF_USER_IO)) begin
			rmii_q  <= reg_wdata[UIO_RMII_BIT];
			xcvr_clock_gate_q <= reg_wdata[UIO_XCVR_CLOCK_GATE_BIT];
		end
	end

	// network control copy: receive enable and statistics write enable
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_en_q    <= RX_EN_RST;
			stats_we_q <= STATS_WE_RST;
		end else if (reg_wr && (reg_addr == OFF_NET_CONTROL)) begin
			rx_en_q    <= reg_wdata[NCTL_RX_EN_BIT];
			stats_we_q <= reg_wdata[NCTL_STATS_WE_BIT];
		end
	end

	// network configuration copy: big frame length limit
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			big_q <= BIG_RST;
		end else if (reg_wr && (reg_addr == OFF_NET_CONFIG)) begin
			big_q <= reg_wdata[NCFG_BIG_BIT];
		end
	end

	// the transceiver clock gate is a level; the cell itself sits in the clock tree
	assign rmii_select     = rmii_q;
	assign xcvr_clock_gate = xcvr_clock_gate_q;
	assign rx_enable       = rx_en_q;
	assign big_frames      = big_q;

	// ------------------------------------------------------------
	// frame event decode
	// ------------------------------------------------------------
	logic len_valid;
	logic frame_good;
	logic crc_fault;
	logic align_fault;
	logic rx_take;
	logic tx_clean;
	logic tx_ok;
	logic pause_ok_tally;
	logic good_frame_tally;
	logic crc_fault_tally;
	logic align_fault_tally;
	logic sent_frame_tally;
	logic one_collision_tally;
	logic many_collision_tally;
	logic deferral_tally;
	logic late_hit_tally;

	rx_frame_classify u_classify (
		.rx_len        (rx_len),
		.rx_dribble    (rx_dribble),
		.rx_crc_bad    (rx_crc_bad),
		.rx_symbol_err (rx_symbol_err),
		.big_frames    (big_q),
		.len_valid     (len_valid),
		.frame_good    (frame_good),
		.crc_fault     (crc_fault),
		.align_fault   (align_fault)
	);

	// receive events only count while receive is switched on
	assign rx_take           = rx_frame_done && rx_en_q;
	assign pause_ok_tally    = rx_take && frame_good && rx_pause;
	assign good_frame_tally  = rx_take && frame_good && rx_addr_match && rx_stored;
	assign crc_fault_tally   = rx_take && crc_fault;
	assign align_fault_tally = rx_take && align_fault;

	// an underrun frame touches no transmit counter at all
	assign tx_clean = tx_frame_done && !tx_underrun;
	assign tx_ok    = tx_clean && !tx_retry_limit;
	assign sent_frame_tally = tx_ok;
	// the collision count already includes any late one, so late hits on frames without a retry limit land here too
	assign one_collision_tally  = tx_ok && (tx_collisions == COLL_ONE);
	assign many_collision_tally = tx_ok && (tx_collisions >= COLL_MULTI_MIN)
		&& (tx_collisions <= COLL_MULTI_MAX);
	assign deferral_tally = tx_clean && tx_deferred && (tx_collisions == '0)
		&& !tx_late_collision;
	// slot time expiry is judged by the transmitter and reported on the late flag
	assign late_hit_tally = tx_clean && tx_late_collision;

	// ------------------------------------------------------------
	// counter bank
	// ------------------------------------------------------------
	logic [NUM_CNT-1:0] cnt_inc;
	logic [NUM_CNT-1:0] cnt_sel;
	logic [NUM_CNT-1:0] cnt_touch;
	logic [DATA_W-1:0]  cnt_val [NUM_CNT];

	assign cnt_inc[IDX_PAUSE]  = pause_ok_tally;
	assign cnt_inc[IDX_TX_OK]  = sent_frame_tally;
	assign cnt_inc[IDX_SINGLE] = one_collision_tally;
	assign cnt_inc[IDX_MULTI]  = many_collision_tally;
	assign cnt_inc[IDX_RX_OK]  = good_frame_tally;
	assign cnt_inc[IDX_CRC]    = crc_fault_tally;
	assign cnt_inc[IDX_ALIGN]  = align_fault_tally;
	assign cnt_inc[IDX_DEFER]  = deferral_tally;
	assign cnt_inc[IDX_LATE]   = late_hit_tally;

	// one counter per entry, each at its own width
	for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
		assign cnt_sel[i]   = (reg_addr == CNT_OFF[i]);
		assign cnt_touch[i] = cnt_sel[i] && (reg_rd || reg_wr);
		stat_sat_counter #(
			.W (CNT_W[i])
		) u_cnt (
			.clk_sys (clk_sys),
			.srst    (srst),
			.inc     (cnt_inc[i]),
			.rd_clr  (reg_rd && cnt_sel[i]),
			.wr_en   (reg_wr && cnt_sel[i] && stats_we_q),
			.wr_data (reg_wdata[CNT_W[i]-1:0]),
			.count   (cnt_val[i])
		);
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] rdata_q;

	// unmapped addresses and unused bits read as zero
	always_comb begin
		rd_mux = '0;
		if (reg_addr == OFF_USER_IO) begin
			rd_mux[UIO_RMII_BIT]  = rmii_q;
			rd_mux[UIO_XCVR_CLOCK_GATE_BIT] = xcvr_clock_gate_q;
		end else if (reg_addr == OFF_NET_CONTROL) begin
			rd_mux[NCTL_RX_EN_BIT]    = rx_en_q;
			rd_mux[NCTL_STATS_WE_BIT] = stats_we_q;
		end else if (reg_addr == OFF_NET_CONFIG) begin
			rd_mux[NCFG_BIG_BIT] = big_q;
		end
		for (int k = 0; k < NUM_CNT; k++) begin
			if (cnt_sel[k]) begin
				rd_mux = cnt_val[k];
			end
		end
	end

	// data stand only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_rmii_follows_write: assert property (
		reg_wr && (reg_addr == OFF_USER_IO) |=> rmii_select == $past(reg_wdata[UIO_RMII_BIT])
	) else $error("interface select did not follow its write");

	a_clock_gate_holds: assert property (
		!srst && !(reg_wr && (reg_addr == OFF_USER_IO)) |=> $stable(xcvr_clock_gate)
	) else $error("transceiver clock gate moved without a write");

	a_read_clears: assert property (
		reg_rd && cnt_sel[IDX_TX_OK] && !sent_frame_tally |=> cnt_val[IDX_TX_OK] == 32'h0000_0000
	) else $error("counter not cleared by its read");

	a_read_keeps_event: assert property (
		reg_rd && cnt_sel[IDX_LATE] && late_hit_tally |=> cnt_val[IDX_LATE] == 32'h0000_0001
	) else $error("event lost in the read clear cycle");

	a_crc_saturates: assert property (
		cnt_val[IDX_CRC] == 32'h0000_00FF && !cnt_touch[IDX_CRC] |=> cnt_val[IDX_CRC] == 32'h0000_00FF
	) else $error("saturated counter wrapped");

	a_rx_gated: assert property (
		!srst && !rx_en_q && !cnt_touch[IDX_RX_OK] && !cnt_touch[IDX_CRC] |=>
			$stable(cnt_val[IDX_RX_OK]) && $stable(cnt_val[IDX_CRC])
	) else $error("receive counter moved while receive disabled");

	a_write_locked: assert property (
		!srst && reg_wr && cnt_sel[IDX_TX_OK] && !stats_we_q && !sent_frame_tally |=>
			$stable(cnt_val[IDX_TX_OK])
	) else $error("counter written without write enable");

	a_write_loads: assert property (
		reg_wr && cnt_sel[IDX_DEFER] && stats_we_q |=>
			cnt_val[IDX_DEFER] == {16'h0000, $past(reg_wdata[15:0])}
	) else $error("enabled counter write did not load");

	a_pause_width: assert property (
		cnt_val[IDX_PAUSE][31:16] == 16'h0000 && cnt_val[IDX_LATE][31:8] == 24'h00_0000
	) else $error("counter bits above its width set");

	a_short_not_good: assert property (
		rx_frame_done && (rx_len < MIN_LEN) |-> !pause_ok_tally && !good_frame_tally && !crc_fault_tally
	) else $error("short frame counted as valid length");

	a_tx_ok_steps: assert property (
		!srst && sent_frame_tally && !cnt_touch[IDX_TX_OK] && cnt_val[IDX_TX_OK] != 32'h00FF_FFFF |=>
			cnt_val[IDX_TX_OK] == $past(cnt_val[IDX_TX_OK]) + 32'h0000_0001
	) else $error("transmit ok counter did not step by one");

	a_single_exact: assert property (
		tx_frame_done && !tx_underrun && !tx_retry_limit && (tx_collisions == COLL_ONE) |-> one_collision_tally
	) else $error("single collision success not counted");

	a_multi_range: assert property (
		many_collision_tally |-> tx_collisions >= COLL_MULTI_MIN && tx_collisions <= COLL_MULTI_MAX && !tx_underrun
	) else $error("multiple collision count outside two to fifteen");

	a_good_stored: assert property (
		good_frame_tally |-> rx_en_q && rx_addr_match && rx_stored && !rx_crc_bad && !rx_symbol_err
	) else $error("bad or unstored frame counted as received ok");

	a_symbol_is_crc: assert property (
		rx_take && len_valid && !rx_dribble && rx_symbol_err |-> crc_fault_tally && !align_fault_tally
	) else $error("symbol error not filed as crc fault");

	a_align_odd_bits: assert property (
		align_fault_tally |-> rx_dribble && len_valid && !crc_fault_tally
	) else $error("alignment fault on a whole byte frame");

	a_defer_excluded: assert property (
		deferral_tally |-> tx_collisions == '0 && !tx_underrun && !tx_late_collision
	) else $error("collided or underrun frame counted as deferred");

	a_late_counts_twice: assert property (
		late_hit_tally && !tx_retry_limit && (tx_collisions == COLL_ONE) |-> one_collision_tally
	) else $error("late collision missing from collision statistics");

	a_unmapped_zero: assert property (
		reg_rd && (cnt_sel == '0) && reg_addr != OFF_USER_IO && reg_addr != OFF_NET_CONTROL
			&& reg_addr != OFF_NET_CONFIG |=> reg_rdata == 32'h0000_0000
	) else $error("unmapped read returned nonzero data");

	a_rdata_one_cycle: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000
	) else $error("read data stood beyond its cycle");
endmodule
`default_nettype wire

/* File: dv/frame_report_model.sv */
// behavioural stand-in for the transceiver side: turns a request into one frame report
`timescale 1ns/1ps
`default_nettype none
module frame_report_model (
	input  wire logic        clk_sys,
	input  wire logic        rx_req,
	input  wire logic        tx_req,
	input  wire logic [25:0] desc,
	output logic             rx_frame_done,
	output logic             tx_frame_done,
	output logic      [25:0] qual
);
	// quiet start so no stray report is seen at time zero
	initial begin
		rx_frame_done = 1'b0;
		tx_frame_done = 1'b0;
		qual = '0;
	end
	// qualifiers mean something only beside a done pulse; between reports they toggle
	// every cycle, so logic that samples them late sees garbage, not the last frame
	always @(posedge clk_sys) begin
		rx_frame_done <= rx_req;
		tx_frame_done <= tx_req;
		qual          <= (rx_req | tx_req) ? desc : ~qual;
	end
endmodule
`default_nettype wire

/* File: dv/eth_mac_stats_counters_tb_top.sv */
// self-checking bench for the user i/o control and statistics counter block
`timescale 1ns/1ps
`default_nettype none
module eth_mac_stats_counters_tb_top;
	import eth_stats_pkg::*;
	typedef struct packed {
		logic        is_rx;
		logic [25:0] desc;
		logic [8:0]  inc;
	} row_s;
	// rx report: length, then drib crc sym pause match stored
	function automatic logic [25:0] rxd(input logic [10:0] len, input logic [5:0] f);
		return {len, f, 9'h000};
	endfunction
	// tx report: underrun retry, collisions, deferred late
	function automatic logic [25:0] txd(input logic [1:0] ur, input logic [4:0] c, input logic [1:0] dl);
		return {17'h0_0000, ur, c, dl};
	endfunction
	// ------------------------------------------------------------
	// one frame per row, beside the counters it should bump (bit = counter index)
	// ------------------------------------------------------------
	localparam row_s ROWS [21] = '{
		'{1'b1, rxd(MIN_LEN, 6'h07), 9'h011}, '{1'b1, rxd(MAX_LEN, 6'h03), 9'h010},
		'{1'b1, rxd(MAX_LEN + 11'h001, 6'h03), 9'h000}, '{1'b1, rxd(MIN_LEN - 11'h001, 6'h07), 9'h000},
		'{1'b1, rxd(MIN_LEN, 6'h10), 9'h020}, '{1'b1, rxd(MAX_LEN, 6'h08), 9'h020},
		'{1'b1, rxd(11'h064, 6'h30), 9'h040}, '{1'b1, rxd(11'h064, 6'h28), 9'h040},
		'{1'b1, rxd(11'h064, 6'h23), 9'h010}, '{1'b1, rxd(11'h064, 6'h02), 9'h000},
		'{1'b1, rxd(11'h7D0, 6'h10), 9'h000}, '{1'b0, txd(2'h0, 5'h00, 2'h0), 9'h002},
		'{1'b0, txd(2'h0, COLL_ONE, 2'h0), 9'h006}, '{1'b0, txd(2'h0, COLL_MULTI_MIN, 2'h0), 9'h00A},
		'{1'b0, txd(2'h0, COLL_MULTI_MAX, 2'h0), 9'h00A}, '{1'b0, txd(2'h1, 5'h10, 2'h0), 9'h000},
		'{1'b0, txd(2'h2, COLL_ONE, 2'h2), 9'h000}, '{1'b0, txd(2'h0, 5'h00, 2'h2), 9'h082},
		'{1'b0, txd(2'h0, COLL_ONE, 2'h2), 9'h006}, '{1'b0, txd(2'h0, COLL_ONE, 2'h1), 9'h106},
		'{1'b0, txd(2'h1, 5'h10, 2'h1), 9'h100}};
	logic              clk_sys = 1'b0;
	logic              srst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              rmii_select;
	logic              xcvr_clock_gate;
	logic              rx_enable;
	logic              big_frames;
	logic              rx_req = 1'b0;
	logic              tx_req = 1'b0;
	logic [25:0]       desc = '0;
	logic              rx_done;
	logic              tx_done;
	logic [25:0]       q;
	int                failures = 0;
	int                n_compared = 0;
	int                cycles = 0;

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	eth_mac_stats_counters u_dut (
		.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rmii_select(rmii_select),
		.xcvr_clock_gate(xcvr_clock_gate), .rx_enable(rx_enable), .big_frames(big_frames),
		.rx_frame_done(rx_done), .rx_len(q[25:15]), .rx_dribble(q[14]), .rx_crc_bad(q[13]),
		.rx_symbol_err(q[12]), .rx_pause(q[11]), .rx_addr_match(q[10]), .rx_stored(q[9]),
		.tx_frame_done(tx_done), .tx_underrun(q[8]), .tx_retry_limit(q[7]), .tx_collisions(q[6:2]),
		.tx_deferred(q[1]), .tx_late_collision(q[0]));
	frame_report_model u_phy (
		.clk_sys(clk_sys), .rx_req(rx_req), .tx_req(tx_req), .desc(desc),
		.rx_frame_done(rx_done), .tx_frame_done(tx_done), .qual(q));

	// ------------------------------------------------------------
	// bus cycles, frames and verdict
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, e);
	endtask
	task automatic frame(input logic rx, input logic [25:0] d);
		@(posedge clk_sys);
		rx_req <= rx;
		tx_req <= ~rx;
		desc <= d;
		@(posedge clk_sys);
		rx_req <= 1'b0;
		tx_req <= 1'b0;
	endtask
	task automatic stop_test();
		if (failures == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		rdc(OFF_USER_IO, 32'h0000_0000, "user_io reset");
		rdc(OFF_NET_CONTROL, 32'h0000_0000, "net_control reset");
		// every select and clock-enable combination; upper bits must drop
		for (int m = 0; m < 4; m++) begin
			wr(OFF_USER_IO, 32'hFFFF_FFFC | m);
			#1;
			chk("rmii_select", rmii_select, m[0]);
			chk("xcvr_clock_gate", xcvr_clock_gate, m[1]);
			rdc(OFF_USER_IO, m, "user_io");
		end
		// only receive enable and the write-enable bit may stick
		wr(OFF_NET_CONTROL, 32'hFFFF_FF7F);
		#1;
		chk("rx_enable", rx_enable, 1'b1);
		rdc(OFF_NET_CONTROL, 32'h0000_0004, "net_control");
		// counters read after every frame so none saturates unseen
		for (int i = 0; i < 21; i++) begin
			frame(ROWS[i].is_rx, ROWS[i].desc);
			for (int k = 0; k < NUM_CNT; k++) begin
				rdc(CNT_OFF[k], {31'h0, ROWS[i].inc[k]}, $sformatf("row%0d cnt%0d", i, k));
			end
		end
		// receive disabled and writes locked
		wr(OFF_NET_CONTROL, 32'h0000_0000);
		frame(1'b1, rxd(MIN_LEN, 6'h07));
		rdc(OFF_RX_OK, 32'h0000_0000, "rx_ok disabled");
		rdc(OFF_PAUSE_RX_OK, 32'h0000_0000, "pause disabled");
		wr(OFF_TX_OK, 32'h0000_0005);
		rdc(OFF_TX_OK, 32'h0000_0000, "tx_ok locked");
		// writes unlocked: saturation, width and clear after read
		wr(OFF_NET_CONTROL, 32'h0000_0084);
		wr(OFF_TX_OK, 32'hFFFF_FFFF);
		frame(1'b0, txd(2'h0, 5'h00, 2'h0));
		rdc(OFF_TX_OK, 32'h00FF_FFFF, "tx_ok sat");
		rdc(OFF_TX_OK, 32'h0000_0000, "tx_ok cleared");
		wr(OFF_CRC_ERR, 32'h0000_00FE);
		frame(1'b1, rxd(MIN_LEN, 6'h10));
		frame(1'b1, rxd(MIN_LEN, 6'h10));
		rdc(OFF_CRC_ERR, 32'h0000_00FF, "crc sat");
		wr(OFF_LATE_COLL, 32'h0000_0005);
		rdc(OFF_LATE_COLL, 32'h0000_0005, "late written");
		@(posedge clk_sys);
		#1;
		chk("rdata after read", reg_rdata, 32'h0000_0000);
		// a read that meets an event in its clearing cycle keeps that one event
		@(posedge clk_sys);
		tx_req <= 1'b1;
		desc <= txd(2'h1, 5'h10, 2'h1);
		@(posedge clk_sys);
		tx_req <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= OFF_LATE_COLL;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("late beside event", reg_rdata, 32'h0000_0000);
		rdc(OFF_LATE_COLL, 32'h0000_0001, "late kept");
		wr(8'h30, 32'hFFFF_FFFF);
		rdc(8'h30, 32'h0000_0000, "unmapped");
		// long-frame limit
		wr(OFF_NET_CONFIG, 32'hFFFF_FFFF);
		#1;
		chk("big_frames", big_frames, 1'b1);
		rdc(OFF_NET_CONFIG, 32'h0000_0100, "net_config");
		frame(1'b1, rxd(MAX_LEN_BIG, 6'h03));
		frame(1'b1, rxd(MAX_LEN_BIG + 11'h001, 6'h03));
		rdc(OFF_RX_OK, 32'h0000_0001, "rx_ok big");
		// second reset in mid-run clears control and counters
		wr(OFF_USER_IO, 32'h0000_0003);
		wr(OFF_DEFER_TX, 32'h0000_0007);
		@(posedge clk_sys);
		srst <= 1'b1;
		@(posedge clk_sys);
		srst <= 1'b0;
		#1;
		chk("rmii after reset", rmii_select, 1'b0);
		chk("big after reset", big_frames, 1'b0);
		chk("clock gate after reset", xcvr_clock_gate, 1'b0);
		chk("rx_enable after reset", rx_enable, 1'b0);
		rdc(OFF_DEFER_TX, 32'h0000_0000, "defer after reset");
		stop_test();
	end
endmodule
`default_nettype wire
